// >>> occ_pkg.sv
package occ_pkg;

    // ----------------------------------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_XCTRL = 8'h10;
    localparam logic [7:0] IDX_STATUS = 8'h11;
    localparam logic [7:0] IDX_IRQ_FLAG = 8'h12;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h13;
    localparam logic [7:0] IDX_PLL_CTRL = 8'h14;
    localparam logic [7:0] IDX_RC_DIV = 8'h15;
    localparam logic [7:0] IDX_RC_STUP = 8'h16;
    localparam logic [7:0] IDX_RC_TRIM = 8'h38;

    // ----------------------------------------------------------------
    // field positions and masks
    // ----------------------------------------------------------------
    localparam int STAT_XRDY = 0;
    localparam int STAT_RCRDY = 1;
    localparam int STAT_LOCK = 2;
    localparam logic [2:0] STAT_MASK = 3'h7;
    localparam logic [31:0] TRIM_MASK = 32'h003F033F;
    localparam logic [2:0] RC_STUP_MASK = 3'h7;

    // ----------------------------------------------------------------
    // reset values and fast RC startup delay base
    // ----------------------------------------------------------------
    localparam logic [2:0] RC_STUP_RST = 3'h7;
    localparam logic [3:0] XSTART_RST = 4'h6;
    localparam logic [2:0] XGAIN_RST = 3'h0;
    localparam logic [31:0] RC_TRIM_RST = 32'h00000000;
    localparam logic [3:0] RC_DIV_RST = 4'h0;
    localparam logic [7:0] RC_STUP_BASE = 8'h08;

    // ----------------------------------------------------------------
    // crystal control register layout, bits 31:16 read zero
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] startup;        // 15:12 settle = 2**startup cycles
        logic auto_amplitude_ctrl;  // 11
        logic [2:0] gain;           // 10:8
        logic run_on_request;       // 7
        logic run_in_standby;       // 6
        logic [2:0] spare;          // 5:3 read zero
        logic crystal_select;       // 2
        logic enable;               // 1
        logic spare0;               // 0 read zero
    } occ_xctrl_s;

    // ----------------------------------------------------------------
    // captured address phase
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] idx;
    } occ_aphase_s;

    typedef enum logic [2:0] {
        XS_OFF = 3'b001,
        XS_SETTLE = 3'b010,
        XS_READY = 3'b100
    } occ_xstate_e;

endpackage : occ_pkg

// >>> occ_oscillator_control.sv
`timescale 1ns/10ps
// Functional notes
// [R1] crystal oscillator runs from external clock on input pin or crystal amplifier
// [R2] after reset oscillator disabled, both pins left to general I/O
// [R3] crystal mode enabled: both oscillator pins overridden
// [R4] external clock mode enabled: only input pin overridden
// [R5] enable bit 1 starts oscillator; 0 keeps it stopped always
// [R6] crystal select 1 picks amplifier, 0 enables external clock input
// [R7] software sets amplifier gain to suit the crystal frequency
// [R8] automatic amplitude control bit 1 lets amplitude self-adjust
// [R9] on-demand and run-in-standby decide running in active, idle, standby
// [R10] output masked for programmed settling time after reset or wake
// [R11] ready flag set once oscillator is stable
// [R12] interrupt on ready rising edge when enabled
// [R13] fast RC startup delay is 8 shifted left by code, reset 7
// [R14] PLL lock cleared while disabled or converging, set at target
// [R15] software loads trim: temp 21:16, band 9:8, freq 5:0
// [R16] divider code n gives fast RC divided by n plus 1
// [R17] peripheral request starts oscillator; output gated until ready
module occ_oscillator_control (
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // system state and requests
    input wire logic standby_i,
    input wire logic crystal_req_i,
    input wire logic rc_tick_i,
    input wire logic pll_at_target_i,
    // oscillator and pin control
    output logic crystal_run_o,
    output logic crystal_mode_o,
    output logic auto_amplitude_ctrl_o,
    output logic [2:0] gain_o,
    output logic osc_in_pin_override_o,
    output logic osc_out_pin_override_o,
    output logic crystal_clk_gate_o,
    output logic crystal_ready_o,
    // fast RC and PLL
    output logic [5:0] temp_trim_o,
    output logic [1:0] freq_band_o,
    output logic [5:0] freq_trim_o,
    output logic fast_rc_ready_o,
    output logic fast_rc_div_tick_o,
    output logic pll_enable_o,
    output logic pll_lock_o,
    // interrupt
    output logic irq_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] settle_cycles(input logic [3:0] code);
        settle_cycles = 16'h0001 << code;
    endfunction : settle_cycles

    function automatic logic [10:0] rc_delay(input logic [2:0] code);
        rc_delay = {3'h0, occ_pkg::RC_STUP_BASE} << code;
    endfunction : rc_delay

    // ----------------------------------------------------------------
    // reset synchroniser
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    occ_pkg::occ_xctrl_s xctrl;
    occ_pkg::occ_aphase_s aph;
    occ_pkg::occ_xstate_e xstate;
    logic [2:0] irq_flag;
    logic [2:0] irq_mask;
    logic pll_en;
    logic [3:0] rc_div;
    logic [2:0] rc_stup;
    logic [31:0] rc_trim;
    logic [15:0] xcnt;
    logic [10:0] rc_cnt;
    logic rc_ready;
    logic [3:0] div_cnt;
    logic [2:0] stat_q;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire accept = hsel_i && hready_i && htrans_i[1];
    wire wr_en = aph.valid && aph.write;
    wire wr_xctrl = wr_en && (aph.idx == occ_pkg::IDX_XCTRL);
    wire wr_flag = wr_en && (aph.idx == occ_pkg::IDX_IRQ_FLAG);
    wire wr_mask = wr_en && (aph.idx == occ_pkg::IDX_IRQ_MASK);
    wire wr_pll = wr_en && (aph.idx == occ_pkg::IDX_PLL_CTRL);
    wire wr_div = wr_en && (aph.idx == occ_pkg::IDX_RC_DIV);
    wire wr_stup = wr_en && (aph.idx == occ_pkg::IDX_RC_STUP);
    wire wr_trim = wr_en && (aph.idx == occ_pkg::IDX_RC_TRIM);
    wire [7:0] rd_idx = haddr_i[9:2];
    wire [2:0] status = {pll_lock_o, rc_ready, crystal_ready_o};

    // read multiplexer, unmapped reads give zero
    logic [31:0] next_rdata;
    always_comb begin
        case (rd_idx)
            occ_pkg::IDX_XCTRL: next_rdata = {16'h0000, xctrl & 16'hFFC6};
            occ_pkg::IDX_STATUS: next_rdata = {29'h0, status};
            occ_pkg::IDX_IRQ_FLAG: next_rdata = {29'h0, irq_flag};
            occ_pkg::IDX_IRQ_MASK: next_rdata = {29'h0, irq_mask};
            occ_pkg::IDX_PLL_CTRL: next_rdata = {31'h0, pll_en};
            occ_pkg::IDX_RC_DIV: next_rdata = {28'h0, rc_div};
            occ_pkg::IDX_RC_STUP: next_rdata = {29'h0, rc_stup};
            occ_pkg::IDX_RC_TRIM: next_rdata = rc_trim;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // address phase capture and read data
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            aph <= '0;
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else if (clk_en_i) begin
            aph <= '{valid: accept, write: hwrite_i, idx: haddr_i[9:2]};
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            if (accept && !hwrite_i) begin
                hrdata_o <= next_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            xctrl <= '{startup: occ_pkg::XSTART_RST, gain: occ_pkg::XGAIN_RST, default: 1'b0}; // R2
            irq_mask <= 3'h0;
            pll_en <= 1'b0;
            rc_div <= occ_pkg::RC_DIV_RST;
            rc_stup <= occ_pkg::RC_STUP_RST; // R13
            rc_trim <= occ_pkg::RC_TRIM_RST;
        end else if (clk_en_i) begin
            if (wr_xctrl) xctrl <= hwdata_i[15:0] & 16'hFFC6;
            if (wr_mask) irq_mask <= hwdata_i[2:0] & occ_pkg::STAT_MASK;
            if (wr_pll) pll_en <= hwdata_i[0];
            if (wr_div) rc_div <= hwdata_i[3:0];
            if (wr_stup) rc_stup <= hwdata_i[2:0] & occ_pkg::RC_STUP_MASK;
            if (wr_trim) rc_trim <= hwdata_i & occ_pkg::TRIM_MASK; // R15
        end
    end

    // ----------------------------------------------------------------
    // crystal oscillator run decision
    // ----------------------------------------------------------------
    wire req_only = xctrl.run_on_request || (standby_i && !xctrl.run_in_standby); // R9
    wire next_run = xctrl.enable && (!req_only || crystal_req_i); // R5 R9 R17

    // settle sequencer: off, masked settling, ready
    occ_pkg::occ_xstate_e next_xstate;
    always_comb begin
        case (xstate)
            occ_pkg::XS_OFF: next_xstate = crystal_run_o ? occ_pkg::XS_SETTLE : occ_pkg::XS_OFF;
            occ_pkg::XS_SETTLE: begin
                if (!crystal_run_o) next_xstate = occ_pkg::XS_OFF;
                else if (xcnt == 16'h0001) next_xstate = occ_pkg::XS_READY;
                else next_xstate = occ_pkg::XS_SETTLE;
            end
            occ_pkg::XS_READY: next_xstate = crystal_run_o ? occ_pkg::XS_READY : occ_pkg::XS_OFF;
            default: next_xstate = occ_pkg::XS_OFF;
        endcase
    end

    // oscillator control, pin override and settling counter
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            xstate <= occ_pkg::XS_OFF;
            xcnt <= 16'h0000;
            crystal_run_o <= 1'b0;
            crystal_mode_o <= 1'b0;
            auto_amplitude_ctrl_o <= 1'b0;
            gain_o <= occ_pkg::XGAIN_RST;
            osc_in_pin_override_o <= 1'b0;
            osc_out_pin_override_o <= 1'b0;
            crystal_clk_gate_o <= 1'b0;
            crystal_ready_o <= 1'b0;
        end else if (clk_en_i) begin
            crystal_run_o <= next_run;
            crystal_mode_o <= xctrl.crystal_select; // R1 R6
            auto_amplitude_ctrl_o <= xctrl.auto_amplitude_ctrl; // R8
            gain_o <= xctrl.gain;
            osc_in_pin_override_o <= xctrl.enable; // R3 R4
            osc_out_pin_override_o <= xctrl.enable && xctrl.crystal_select; // R3 R4
            xstate <= next_xstate;
            if (xstate == occ_pkg::XS_OFF) xcnt <= settle_cycles(xctrl.startup); // R10
            else if (xcnt != 16'h0000) xcnt <= xcnt - 16'h0001;
            crystal_ready_o <= next_xstate == occ_pkg::XS_READY; // R11
            crystal_clk_gate_o <= next_xstate == occ_pkg::XS_READY; // R10 R17
        end
    end

    // ----------------------------------------------------------------
    // fast RC startup, divider, trim and PLL lock
    // ----------------------------------------------------------------
    wire div_wrap = (div_cnt >= rc_div);
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rc_cnt <= 11'h000;
            rc_ready <= 1'b0;
            div_cnt <= 4'h0;
            fast_rc_ready_o <= 1'b0;
            fast_rc_div_tick_o <= 1'b0;
            temp_trim_o <= 6'h00;
            freq_band_o <= 2'h0;
            freq_trim_o <= 6'h00;
            pll_enable_o <= 1'b0;
            pll_lock_o <= 1'b0;
        end else if (clk_en_i) begin
            if (!rc_ready && rc_tick_i) begin
                rc_cnt <= rc_cnt + 11'h001;
                rc_ready <= (rc_cnt + 11'h001) >= rc_delay(rc_stup); // R13
            end
            fast_rc_ready_o <= rc_ready;
            fast_rc_div_tick_o <= 1'b0;
            if (rc_ready && rc_tick_i) begin
                div_cnt <= div_wrap ? 4'h0 : div_cnt + 4'h1;
                fast_rc_div_tick_o <= div_wrap; // R16
            end
            temp_trim_o <= rc_trim[21:16];
            freq_band_o <= rc_trim[9:8];
            freq_trim_o <= rc_trim[5:0];
            pll_enable_o <= pll_en;
            pll_lock_o <= pll_en && pll_at_target_i; // R14
        end
    end

    // ----------------------------------------------------------------
    // interrupt flags, write one to clear, a new event wins
    // ----------------------------------------------------------------
    wire [2:0] rise = status & ~stat_q;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= 3'h0;
            irq_flag <= 3'h0;
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            stat_q <= status;
            irq_flag <= (irq_flag & ~(wr_flag ? hwdata_i[2:0] : 3'h0)) | rise; // R12
            irq_o <= |(((irq_flag & ~(wr_flag ? hwdata_i[2:0] : 3'h0)) | rise) & irq_mask); // R12
        end
    end

endmodule : occ_oscillator_control

// >>> occ_osc_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// oscillator controller port checker
// ----------------------------------------------------------------
module occ_osc_assertions (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // bus answer
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // crystal oscillator control
    input wire logic crystal_run_o,
    input wire logic osc_in_pin_override_o,
    input wire logic osc_out_pin_override_o,
    input wire logic crystal_clk_gate_o,
    input wire logic crystal_ready_o,
    // pll and interrupt
    input wire logic pll_enable_o,
    input wire logic pll_at_target_i,
    input wire logic pll_lock_o,
    input wire logic irq_o
);
    // all checks share the core clock and its reset
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // zero wait states and always okay
    AST_HREADY: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not okay");
    // output pin only taken together with input pin
    AST_OUT_OVR: assert property (osc_out_pin_override_o |-> osc_in_pin_override_o)
        else $error("output pin taken without input pin");
    // oscillator never runs unless enabled now or a cycle ago
    AST_RUN_EN: assert property (crystal_run_o |-> osc_in_pin_override_o || $past(osc_in_pin_override_o))
        else $error("oscillator running while disabled");
    // clock passes only once ready
    AST_GATE: assert property (crystal_clk_gate_o |-> crystal_ready_o)
        else $error("clock passed before ready");
    // ready only follows a running oscillator
    AST_READY_RUN: assert property (crystal_ready_o |-> $past(crystal_run_o))
        else $error("ready without running oscillator");
    // output masked through the shortest settling time after each start
    AST_SETTLE: assert property ($rose(crystal_run_o) |-> (!crystal_clk_gate_o) [*2])
        else $error("clock passed during settling");
    // lock moves with the enable output and follows target one cycle later
    AST_LOCK: assert property (pll_lock_o == (pll_enable_o && $past(pll_at_target_i)))
        else $error("lock does not follow pll state");
    // pin override, oscillator run and interrupt idle for three cycles after reset release
    AST_RST_IDLE: assert property ($rose(rst_n_i) |-> (!osc_in_pin_override_o && !crystal_run_o && !irq_o) [*3])
        else $error("oscillator active after reset");
endmodule : occ_osc_assertions

bind occ_oscillator_control occ_osc_assertions u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .crystal_run_o(crystal_run_o),
    .osc_in_pin_override_o(osc_in_pin_override_o), .osc_out_pin_override_o(osc_out_pin_override_o),
    .crystal_clk_gate_o(crystal_clk_gate_o), .crystal_ready_o(crystal_ready_o),
    .pll_enable_o(pll_enable_o), .pll_at_target_i(pll_at_target_i), .pll_lock_o(pll_lock_o),
    .irq_o(irq_o));

// >>> occ_osc_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// far side: fast rc source and pll settling
// ----------------------------------------------------------------
module occ_osc_model #(
    parameter int TICK_DIV = 4,
    parameter int PLL_DLY = 20
) (
    // clock and pll enable
    input wire logic clk_i,
    input wire logic pll_en_i,
    // rc tick and pll state
    output logic rc_tick_o,
    output logic at_target_o
);
    int tdiv = 0;
    int pcnt = 0;

    // free running rc tick, pll reaches target after a delay
    always @(posedge clk_i) begin
        tdiv <= (tdiv == TICK_DIV - 1) ? 0 : tdiv + 1;
        rc_tick_o <= (tdiv == 0);
        pcnt <= pll_en_i ? pcnt + int'(pcnt < PLL_DLY) : 0;
        at_target_o <= pll_en_i && (pcnt == PLL_DLY);
    end
endmodule : occ_osc_model

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic core_clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, standby = 1'h0, req = 1'h0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, rd, hrdata;
    logic hready, hresp, run, mode, aac, in_ovr, out_ovr, gate, rdy, rc_rdy, dtick, pll_en;
    logic lock, irq, rc_tick, at_tgt;
    logic [2:0] gain;
    logic [5:0] ttrim, ftrim;
    logic [1:0] band;
    int err_total = 0, cmp_count = 0, cycles = 0, k, c;
    int dv[3] = '{0, 3, 15};
    logic [31:0] tbl[8] = '{32'h0000_6082, 32'h0006_6082, 32'h0001_6002, 32'h0005_6042,
                            32'h0001_60C2, 32'h0007_60C2, 32'h0002_0000, 32'h0004_6002};

    occ_oscillator_control dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .clk_en_i(1'h1),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .standby_i(standby), .crystal_req_i(req), .rc_tick_i(rc_tick),
        .pll_at_target_i(at_tgt), .crystal_run_o(run), .crystal_mode_o(mode),
        .auto_amplitude_ctrl_o(aac), .gain_o(gain), .osc_in_pin_override_o(in_ovr),
        .osc_out_pin_override_o(out_ovr), .crystal_clk_gate_o(gate), .crystal_ready_o(rdy),
        .temp_trim_o(ttrim), .freq_band_o(band), .freq_trim_o(ftrim), .fast_rc_ready_o(rc_rdy),
        .fast_rc_div_tick_o(dtick), .pll_enable_o(pll_en), .pll_lock_o(lock), .irq_o(irq));
    occ_osc_model u_model (.clk_i(core_clk), .pll_en_i(pll_en), .rc_tick_o(rc_tick),
        .at_target_o(at_tgt));

    // ----------------------------------------------------------------
    // clock, timeout and helper tasks
    // ----------------------------------------------------------------
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // single word transfer, read data left in rd
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {2'h0, idx, 2'h0};
        do @(posedge core_clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'h1);
        rd = hrdata;
    endtask : bus

    // cycles between two divided rc ticks
    task automatic gap(output int n);
        n = 0;
        do @(posedge core_clk); while (dtick !== 1'h1);
        do begin
            @(posedge core_clk);
            n++;
        end while (dtick !== 1'h1);
    endtask : gap

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge core_clk);
        bus(1'h0, occ_pkg::IDX_RC_STUP, 32'h0);
        chk(rd, 32'h7);
        bus(1'h0, occ_pkg::IDX_XCTRL, 32'h0);
        chk(rd, 32'h6000);
        bus(1'h1, 8'h20, 32'hFFFF_FFFF);
        bus(1'h0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        bus(1'h1, occ_pkg::IDX_RC_TRIM, 32'hFFFF_FFFF);
        bus(1'h0, occ_pkg::IDX_RC_TRIM, 32'h0);
        chk(rd, 32'h003F_033F);
        bus(1'h1, occ_pkg::IDX_RC_TRIM, 32'h002A_0215);
        repeat (2) @(posedge core_clk);
        chk({ttrim, band, ftrim}, 32'h2A95);
        // rc startup of 1024 ticks, four core cycles each
        repeat (3900) @(posedge core_clk);
        chk(rc_rdy, 1'h0);
        for (k = 0; k < 300 && rc_rdy !== 1'h1; k++) @(posedge core_clk);
        chk(rc_rdy, 1'h1);
        repeat (3) @(posedge core_clk);
        chk(irq, 1'h0);
        foreach (dv[i]) begin
            bus(1'h1, occ_pkg::IDX_RC_DIV, dv[i]);
            gap(c);
            gap(c);
            chk(c, (dv[i] + 1) * 4);
        end
        // crystal mode start, ready and interrupt
        bus(1'h1, occ_pkg::IDX_IRQ_FLAG, 32'h7);
        bus(1'h1, occ_pkg::IDX_IRQ_MASK, 32'h1);
        bus(1'h1, occ_pkg::IDX_XCTRL, 32'h6F06);
        repeat (2) @(posedge core_clk);
        chk({in_ovr, out_ovr, mode}, 32'h7);
        chk({aac, gain}, 32'hF);
        repeat (30) @(posedge core_clk);
        chk(gate, 1'h0);
        for (k = 0; k < 60 && rdy !== 1'h1; k++) @(posedge core_clk);
        chk({rdy, gate}, 32'h3);
        repeat (3) @(posedge core_clk);
        chk(irq, 1'h1);
        bus(1'h1, occ_pkg::IDX_IRQ_FLAG, 32'h1);
        repeat (3) @(posedge core_clk);
        chk(irq, 1'h0);
        bus(1'h1, occ_pkg::IDX_XCTRL, 32'h6002);
        repeat (2) @(posedge core_clk);
        chk({in_ovr, out_ovr, mode}, 32'h4);
        // run state against standby, on-demand and request
        for (k = 0; k < 8; k++) begin
            standby <= tbl[k][16];
            req <= tbl[k][17];
            bus(1'h1, occ_pkg::IDX_XCTRL, {16'h0, tbl[k][15:0]});
            repeat (3) @(posedge core_clk);
            chk(run, tbl[k][18]);
        end
        bus(1'h1, occ_pkg::IDX_XCTRL, 32'h0);
        repeat (3) @(posedge core_clk);
        chk({run, in_ovr, out_ovr, rdy}, 32'h0);
        // pll lock follows target
        bus(1'h1, occ_pkg::IDX_PLL_CTRL, 32'h1);
        repeat (2) @(posedge core_clk);
        chk({pll_en, lock}, 32'h2);
        for (k = 0; k < 40 && lock !== 1'h1; k++) @(posedge core_clk);
        bus(1'h0, occ_pkg::IDX_STATUS, 32'h0);
        chk({lock, rd[occ_pkg::STAT_LOCK]}, 32'h3);
        bus(1'h1, occ_pkg::IDX_PLL_CTRL, 32'h0);
        repeat (2) @(posedge core_clk);
        chk({pll_en, lock}, 32'h0);
        finish_test();
    end
endmodule : tb_top
